// ---- rtl/scan_mode_pkg.sv ----
// Purpose: shared constants and types for the scan mode control block
// Assumes: 125 MHz system clock, 32-bit Avalon-MM register bus
// Notes: byte addresses, one aligned word per register
package scan_mode_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned HOLD_TIME_S = 5;
  localparam int unsigned HOLD_CYCLES = HOLD_TIME_S * CLK_MHZ * 1000000;
  localparam int unsigned HOLD_W = 30;
  localparam int unsigned STEP_HALF_NS = 4000;
  localparam int unsigned STEP_HALF_CYC = STEP_HALF_NS * CLK_MHZ / 1000;
  localparam int unsigned STEP_W = 9;
  localparam int unsigned POS_W = 11;
  localparam int unsigned JOG_N = 7;
  // register byte addresses
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_X_ORG = 5'h04;
  localparam logic [4:0] REG_Y_ORG = 5'h08;
  localparam logic [4:0] REG_Z_ORG = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [10:0] ORG_RST = 11'h000;
  // control fields
  localparam int unsigned CTRL_FINE = 0;
  localparam int unsigned CTRL_CMD_LSB = 1;
  // status fields
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_SEQ_LSB = 5;
  localparam int unsigned STAT_LOCK = 7;
  localparam int unsigned STAT_JOG_LSB = 8;
  localparam int unsigned STAT_STOP = 15;
  localparam int unsigned STAT_MATCH = 16;
  localparam int unsigned STAT_AUTO = 17;
  localparam int unsigned STAT_MANUAL = 18;
  // jog flag positions
  localparam int unsigned JOG_XP = 0;
  localparam int unsigned JOG_XN = 1;
  localparam int unsigned JOG_YP = 2;
  localparam int unsigned JOG_YN = 3;
  localparam int unsigned JOG_ZP = 4;
  localparam int unsigned JOG_ZN = 5;
  // button positions
  localparam int unsigned BTN_AUTO = 0;
  localparam int unsigned BTN_MANUAL = 1;
  // origin search sequence codes
  localparam logic [1:0] SEQ_INIT = 2'h3;
  localparam logic [1:0] SEQ_Y = 2'h2;
  localparam logic [1:0] SEQ_Z = 2'h1;
  localparam logic [1:0] SEQ_DONE = 2'h0;
  typedef enum logic [4:0] {
    S_HOLD = 5'b00001,
    S_READY = 5'b00010,
    S_SEARCH = 5'b00100,
    S_SCAN = 5'b01000,
    S_MANUAL = 5'b10000
  } mode_t;
endpackage : scan_mode_pkg

// ---- rtl/edge_sync.sv ----
// Purpose: two-stage synchroniser with rising edge detect per bit
// Assumes: single clock, synchronous active low reset
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
module edge_sync #(
  parameter int unsigned W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [W-1:0] i_din,
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // sample, settle and remember last level
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else if (i_ce) begin
      meta_r <= i_din;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign o_level = sync_r;
  assign o_rise = sync_r & ~prev_r;
endmodule : edge_sync

// ---- rtl/powerup_hold.sv ----
// Purpose: power-up hold timer that clamps the mode logic
// Assumes: CYCLES at least one
// Notes: release is synchronous, hold stays low once released
`timescale 1ns/1ps
module powerup_hold #(
  parameter int unsigned CYCLES = scan_mode_pkg::HOLD_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  output logic o_hold
);
  localparam logic [scan_mode_pkg::HOLD_W-1:0] LAST =
    scan_mode_pkg::HOLD_W'(CYCLES - 1);
  logic [scan_mode_pkg::HOLD_W-1:0] cnt_r;
  logic done_r;

  // count clock cycles until the hold time has passed
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else if (i_ce && !done_r) begin
      if (cnt_r == LAST) begin
        done_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  assign o_hold = ~done_r;
endmodule : powerup_hold

// ---- rtl/scan_mode_control.sv ----
// Purpose: scan mode control, origin search, jog and axis routing
// Assumes: inputs synchronous to i_clk; start-stop logic is external
// Notes: command lines are registered, bus answers after one wait
// Summary of operation
// - hold mode state for five seconds after power
// - hold end clears lock, shows ready
// - first button sets mode and lock, later ignored
// - manual jog flag forces dwell override
// - auto search uses match and direction compare
// - two-bit sequencer from ones: X, Y, Z, done
// - drive three enables, sign and motor clock
// - search sign follows less-or-equal compare
// - setup keeps motor clock enabled
// - match rise advances sequencer by one
// - compare encoder of active axis only
// - Z origin: scan enable, clear auto, freeze
// - jog flags cleared during origin search
// - fine step: one switch press, one flag
// - clock enable fall clears all jog flags
// - auto scan, fine bit clear: routes programmer, blocks jog
// - manual: hold moves, release stops at digit
// - dwell override pulse or steady level
// - programmer gets commands, match, dwell; gives axes
// - match high when encoder equals target
// - programmer enables OR, sign AND-OR merge
`timescale 1ns/1ps
module scan_mode_control #(
  parameter int unsigned HOLD_CYCLES = scan_mode_pkg::HOLD_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_auto_btn,
  input wire logic i_manual_btn,
  input wire logic [6:0] i_jog_sw,
  input wire logic i_digit_step,
  input wire logic i_clock_enable,
  input wire logic i_dwell_done_pulse,
  input wire logic [10:0] i_x_position,
  input wire logic [10:0] i_y_position,
  input wire logic [10:0] i_z_position,
  input wire logic [1:0] i_prog_x_end,
  input wire logic [1:0] i_prog_y_end,
  input wire logic [1:0] i_prog_z_end,
  input wire logic [2:0] i_prog_dir,
  input wire logic i_prog_stop,
  output logic o_x_axis_enable,
  output logic o_y_axis_enable,
  output logic o_z_axis_enable,
  output logic o_sign,
  output logic o_motor_clock,
  output logic o_dwell_override,
  output logic o_setup_active,
  output logic o_scan_enable,
  output logic o_ready,
  output logic o_position_match,
  output logic [2:0] o_prog_cmd,
  output logic o_prog_match_pulse,
  output logic o_prog_dwell_pulse
);
  scan_mode_pkg::mode_t state_r;
  scan_mode_pkg::mode_t state_nxt;
  logic hold;
  logic [1:0] btn_rise;
  logic [6:0] jog_lvl;
  logic [6:0] jog_rise;
  logic [6:0] jog_r;
  logic [6:0] pick;
  logic [1:0] seq_r;
  logic lock_r;
  logic auto_r;
  logic manual_r;
  logic fine_r;
  logic search;
  logic scan;
  logic prog_route;
  logic jog_allowed;
  logic jog_set;
  logic match_d_r;
  logic match_rise;
  logic pos_le;
  logic [10:0] x_origin_point;
  logic [10:0] y_origin_point;
  logic [10:0] z_origin_point;
  logic [10:0] pos_sel;
  logic [10:0] tgt_sel;
  logic prog_x;
  logic prog_y;
  logic prog_z;
  logic x_enable_merge_gate;
  logic y_enable_merge_gate;
  logic z_enable_merge_gate;
  logic sign_merge_gate;
  logic run;
  logic run_d_r;
  logic run_fall;
  logic [scan_mode_pkg::STEP_W-1:0] div_r;
  logic ack_r;
  logic req;
  logic wr_go;
  logic [31:0] rd_mux;

  // counted power-up hold and input conditioning
  powerup_hold #(.CYCLES(HOLD_CYCLES)) u_hold (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .o_hold(hold)
  );

  edge_sync #(.W(2)) u_btn (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_din({i_manual_btn, i_auto_btn}),
    .o_level(),
    .o_rise(btn_rise)
  );

  edge_sync #(.W(scan_mode_pkg::JOG_N)) u_jog (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_din(i_jog_sw),
    .o_level(jog_lvl),
    .o_rise(jog_rise)
  );

  assign search = (state_r == scan_mode_pkg::S_SEARCH);
  assign scan = (state_r == scan_mode_pkg::S_SCAN);

  // mode sequence: hold, ready, then auto search or manual
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      scan_mode_pkg::S_HOLD: begin
        if (!hold) state_nxt = scan_mode_pkg::S_READY;
      end
      scan_mode_pkg::S_READY: begin
        if (btn_rise[scan_mode_pkg::BTN_AUTO]) begin
          state_nxt = scan_mode_pkg::S_SEARCH;
        end else if (btn_rise[scan_mode_pkg::BTN_MANUAL]) begin
          state_nxt = scan_mode_pkg::S_MANUAL;
        end
      end
      scan_mode_pkg::S_SEARCH: begin
        if (seq_r == scan_mode_pkg::SEQ_DONE) begin
          state_nxt = scan_mode_pkg::S_SCAN;
        end
      end
      scan_mode_pkg::S_SCAN: state_nxt = state_r;
      scan_mode_pkg::S_MANUAL: state_nxt = state_r;
      default: state_nxt = scan_mode_pkg::S_HOLD;
    endcase
    if (hold) state_nxt = scan_mode_pkg::S_HOLD;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) state_r <= scan_mode_pkg::S_HOLD;
    else if (i_ce) state_r <= state_nxt;
  end

  // mode lock: set in hold, cleared at release, set by a button
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      lock_r <= 1'b1;
    end else if (i_ce) begin
      if (hold) lock_r <= 1'b1;
      else if (state_r == scan_mode_pkg::S_HOLD) lock_r <= 1'b0;
      else if (state_r == scan_mode_pkg::S_READY && |btn_rise)
        lock_r <= 1'b1;
    end
  end

  // mode flags, auto wins when both buttons rise together
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      auto_r <= 1'b0;
      manual_r <= 1'b0;
    end else if (i_ce) begin
      if (hold) begin
        auto_r <= 1'b0;
        manual_r <= 1'b0;
      end else if (state_r == scan_mode_pkg::S_READY) begin
        auto_r <= btn_rise[scan_mode_pkg::BTN_AUTO];
        manual_r <= btn_rise[scan_mode_pkg::BTN_MANUAL] &
                    ~btn_rise[scan_mode_pkg::BTN_AUTO];
      end else if (search && seq_r == scan_mode_pkg::SEQ_DONE) begin
        auto_r <= 1'b0;
      end
    end
  end

  // origin search sequencer counts down from all ones
  assign match_rise = o_position_match & ~match_d_r;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      seq_r <= scan_mode_pkg::SEQ_INIT;
      match_d_r <= 1'b0;
    end else if (i_ce) begin
      match_d_r <= o_position_match;
      if (hold) seq_r <= scan_mode_pkg::SEQ_INIT;
      else if (search && match_rise && seq_r != scan_mode_pkg::SEQ_DONE)
        seq_r <= seq_r - 2'h1;
    end
  end

  // programmer merge of endpoint and direction flags
  assign prog_x = |i_prog_x_end;
  assign prog_y = |i_prog_y_end;
  assign prog_z = |i_prog_z_end;
  assign prog_route = scan & ~fine_r;

  // axis select: search decode, programmer or jog flags
  always_comb begin
    if (search) begin
      x_enable_merge_gate = (seq_r == scan_mode_pkg::SEQ_INIT);
      y_enable_merge_gate = (seq_r == scan_mode_pkg::SEQ_Y);
      z_enable_merge_gate = (seq_r == scan_mode_pkg::SEQ_Z);
    end else if (prog_route) begin
      x_enable_merge_gate = prog_x;
      y_enable_merge_gate = prog_y;
      z_enable_merge_gate = prog_z;
    end else begin
      x_enable_merge_gate = jog_r[scan_mode_pkg::JOG_XP] |
                            jog_r[scan_mode_pkg::JOG_XN];
      y_enable_merge_gate = jog_r[scan_mode_pkg::JOG_YP] |
                            jog_r[scan_mode_pkg::JOG_YN];
      z_enable_merge_gate = jog_r[scan_mode_pkg::JOG_ZP] |
                            jog_r[scan_mode_pkg::JOG_ZN];
    end
  end

  // encoder and target of the active axis feed the comparator
  always_comb begin
    pos_sel = 11'h000;
    tgt_sel = 11'h000;
    case ({z_enable_merge_gate, y_enable_merge_gate, x_enable_merge_gate})
      3'b001: begin
        pos_sel = i_x_position;
        tgt_sel = x_origin_point;
      end
      3'b010: begin
        pos_sel = i_y_position;
        tgt_sel = y_origin_point;
      end
      3'b100: begin
        pos_sel = i_z_position;
        tgt_sel = z_origin_point;
      end
      default: begin
        pos_sel = 11'h000;
        tgt_sel = 11'h000;
      end
    endcase
  end

  assign pos_le = (pos_sel <= tgt_sel);

  // sign: compare in search, programmer merge or jog direction
  always_comb begin
    if (search) begin
      sign_merge_gate = pos_le;
    end else if (prog_route) begin
      sign_merge_gate = (prog_x & i_prog_dir[0]) |
                        (prog_y & i_prog_dir[1]) |
                        (prog_z & i_prog_dir[2]);
    end else begin
      sign_merge_gate = jog_r[scan_mode_pkg::JOG_XP] |
                        jog_r[scan_mode_pkg::JOG_YP] |
                        jog_r[scan_mode_pkg::JOG_ZP];
    end
  end

  // registered command lines and comparator result
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_x_axis_enable <= 1'b0;
      o_y_axis_enable <= 1'b0;
      o_z_axis_enable <= 1'b0;
      o_sign <= 1'b0;
      o_position_match <= 1'b0;
    end else if (i_ce) begin
      o_x_axis_enable <= x_enable_merge_gate;
      o_y_axis_enable <= y_enable_merge_gate;
      o_z_axis_enable <= z_enable_merge_gate;
      o_sign <= sign_merge_gate;
      o_position_match <= (pos_sel == tgt_sel) &
        (x_enable_merge_gate | y_enable_merge_gate |
         z_enable_merge_gate);
    end
  end

  // jog flags, single axis chosen by lowest bit
  assign jog_allowed = manual_r | (scan & fine_r);
  assign pick = jog_rise & (~jog_rise + 7'h01);
  assign jog_set = jog_allowed & (jog_r == 7'h00) & (|jog_rise);
  assign run = i_clock_enable | search;
  assign run_fall = run_d_r & ~run;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      jog_r <= 7'h00;
      run_d_r <= 1'b0;
    end else if (i_ce) begin
      run_d_r <= run;
      if (!jog_allowed) jog_r <= 7'h00;
      else if (jog_set) jog_r <= pick;
      else if (run_fall) jog_r <= 7'h00;
      else if (manual_r && i_digit_step)
        jog_r <= jog_r & jog_lvl;
    end
  end

  // dwell override: level in manual, one pulse per fine step
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) o_dwell_override <= 1'b0;
    else if (i_ce)
      o_dwell_override <= manual_r ? |jog_r : jog_set;
  end

  // motor clock runs while enabled, low otherwise
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      div_r <= '0;
      o_motor_clock <= 1'b0;
    end else if (i_ce) begin
      if (!run) begin
        div_r <= '0;
        o_motor_clock <= 1'b0;
      end else if (div_r ==
          scan_mode_pkg::STEP_W'(scan_mode_pkg::STEP_HALF_CYC - 1)) begin
        div_r <= '0;
        o_motor_clock <= ~o_motor_clock;
      end else begin
        div_r <= div_r + 1'b1;
      end
    end
  end

  // programmer strobes: match and dwell pulses during scan
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_prog_match_pulse <= 1'b0;
      o_prog_dwell_pulse <= 1'b0;
    end else if (i_ce) begin
      o_prog_match_pulse <= scan & match_rise;
      o_prog_dwell_pulse <= scan & i_dwell_done_pulse;
    end
  end

  assign o_setup_active = search;
  assign o_scan_enable = scan;
  assign o_ready = (state_r == scan_mode_pkg::S_READY);

  // bus slave: one wait state, then the answer
  assign req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~(ack_r & i_ce);
  assign wr_go = i_ce & i_avs_write & ack_r;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) ack_r <= 1'b0;
    else if (i_ce) ack_r <= req & ~ack_r;
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_avs_address)
      scan_mode_pkg::REG_CTRL: rd_mux[scan_mode_pkg::CTRL_FINE] = fine_r;
      scan_mode_pkg::REG_X_ORG: rd_mux[10:0] = x_origin_point;
      scan_mode_pkg::REG_Y_ORG: rd_mux[10:0] = y_origin_point;
      scan_mode_pkg::REG_Z_ORG: rd_mux[10:0] = z_origin_point;
      scan_mode_pkg::REG_STATUS: begin
        rd_mux[scan_mode_pkg::STAT_STATE_LSB +: 5] = state_r;
        rd_mux[scan_mode_pkg::STAT_SEQ_LSB +: 2] = seq_r;
        rd_mux[scan_mode_pkg::STAT_LOCK] = lock_r;
        rd_mux[scan_mode_pkg::STAT_JOG_LSB +: 7] = jog_r;
        rd_mux[scan_mode_pkg::STAT_STOP] = i_prog_stop;
        rd_mux[scan_mode_pkg::STAT_MATCH] = o_position_match;
        rd_mux[scan_mode_pkg::STAT_AUTO] = auto_r;
        rd_mux[scan_mode_pkg::STAT_MANUAL] = manual_r;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // register writes and command pulses toward the programmer
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_avs_readdata <= 32'h0000_0000;
      fine_r <= 1'b0;
      x_origin_point <= scan_mode_pkg::ORG_RST;
      y_origin_point <= scan_mode_pkg::ORG_RST;
      z_origin_point <= scan_mode_pkg::ORG_RST;
      o_prog_cmd <= 3'h0;
    end else if (i_ce) begin
      if (i_avs_read && !ack_r) o_avs_readdata <= rd_mux;
      o_prog_cmd <= 3'h0;
      if (wr_go) begin
        case (i_avs_address)
          scan_mode_pkg::REG_CTRL: begin
            fine_r <= i_avs_writedata[scan_mode_pkg::CTRL_FINE];
            o_prog_cmd <=
              i_avs_writedata[scan_mode_pkg::CTRL_CMD_LSB +: 3];
          end
          scan_mode_pkg::REG_X_ORG: x_origin_point <= i_avs_writedata[10:0];
          scan_mode_pkg::REG_Y_ORG: y_origin_point <= i_avs_writedata[10:0];
          scan_mode_pkg::REG_Z_ORG: z_origin_point <= i_avs_writedata[10:0];
          default: fine_r <= fine_r;
        endcase
      end
    end
  end

  // checks on mode, search and jog behaviour
  chk_hold_clamp: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    hold |-> ##1 (lock_r && seq_r == 2'h3 && !auto_r))
    else $error("hold did not clamp mode state");
  chk_ready_unlock: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_ready |-> !lock_r)
    else $error("ready shown while locked");
  chk_lock_stays: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (lock_r && !hold && state_r != scan_mode_pkg::S_HOLD) |=> lock_r)
    else $error("mode lock released without power cycle");
  chk_dwell_level: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && manual_r && jog_r != 7'h00) |=> o_dwell_override)
    else $error("dwell override missing in manual jog");
  chk_search_sign: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && search) |=> o_sign == $past(pos_le))
    else $error("search sign not from compare");
  chk_seq_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && search && match_rise && seq_r != 2'h0 && !hold)
    |=> seq_r == $past(seq_r) - 2'h1)
    else $error("sequencer did not advance on match");
  chk_search_done: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && !hold && search && seq_r == 2'h0)
    |=> (o_scan_enable && !auto_r && seq_r == 2'h0))
    else $error("search end did not enter scan");
  chk_search_jog: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    search |-> jog_r == 7'h00)
    else $error("jog flag set during search");
  chk_jog_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && run_fall && !jog_set) |=> jog_r == 7'h00)
    else $error("jog flags survived clock enable fall");
  chk_scan_route: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && prog_route) |=> (o_x_axis_enable == $past(prog_x) &&
    o_z_axis_enable == $past(prog_z)))
    else $error("programmer enables not routed in scan");
  chk_one_axis: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $onehot0({o_x_axis_enable, o_y_axis_enable, o_z_axis_enable}))
    else $error("more than one axis enabled");
endmodule : scan_mode_control

// ---- bench/axis_stage_model.sv ----
// Purpose: stage model behind the command lines, three stepper axes
// Assumes: positions stay inside one decimal digit, so BCD = binary
// Notes: one step per motor clock rise, digit pulse on every step
`timescale 1ns/1ps
module axis_stage_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_x_en,
  input wire logic i_y_en,
  input wire logic i_z_en,
  input wire logic i_sign,
  input wire logic i_mclk,
  output logic [10:0] o_x,
  output logic [10:0] o_y,
  output logic [10:0] o_z,
  output logic o_step
);
  logic mclk_r;
  // steer each clock rise to the enabled axis, sign high moves up
  always_ff @(posedge i_clk) begin
    mclk_r <= i_mclk;
    o_step <= 1'b0;
    if (!i_rst_n) begin
      o_x <= 11'h001;
      o_y <= 11'h005;
      o_z <= 11'h000;
    end else if (i_mclk && !mclk_r) begin
      o_step <= i_x_en | i_y_en | i_z_en;
      if (i_x_en) o_x <= i_sign ? o_x + 11'h001 : o_x - 11'h001;
      if (i_y_en) o_y <= i_sign ? o_y + 11'h001 : o_y - 11'h001;
      if (i_z_en) o_z <= i_sign ? o_z + 11'h001 : o_z - 11'h001;
    end
  end
endmodule : axis_stage_model

// ---- bench/scan_mode_control_tb.sv ----
// Purpose: self-checking bench for scan mode control
// Assumes: hold shortened to 20 cycles
// Notes: start-stop logic and stage are modelled here
`timescale 1ns/1ps
module scan_mode_control_tb;
  localparam int HC = 20;
  logic clk, rst_n, rd, wr, ab, mb, dwp, cen;
  logic [4:0] addr;
  logic [31:0] wd, rdat, q;
  logic wreq, xe, ye, ze, sg, mc, ov, se, rdy, pdp, stp, sa, pm, pmp;
  logic [6:0] jog;
  logic [1:0] pxe, pye;
  logic [2:0] pdir, cmd;
  logic [10:0] px, py, pz, y0;
  logic [2:0] cseen = 3'h0;
  logic dseen = 1'b0;
  logic mseen = 1'b0;
  logic pseen = 1'b0;
  int ovn = 0;
  int n_fail = 0;
  int n_checks = 0;
  int wn, o;
  wire [4:0] ev = {se, ze, ye, xe, rdy};
  scan_mode_control #(.HOLD_CYCLES(HC)) dut (.i_clk(clk), .i_rst_n(rst_n),
    .i_ce(1'b1), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_auto_btn(ab), .i_manual_btn(mb), .i_jog_sw(jog), .i_digit_step(stp),
    .i_clock_enable(cen), .i_dwell_done_pulse(dwp), .i_x_position(px),
    .i_y_position(py), .i_z_position(pz), .i_prog_x_end(pxe),
    .i_prog_y_end(pye), .i_prog_z_end(2'h0), .i_prog_dir(pdir),
    .i_prog_stop(1'b0), .o_x_axis_enable(xe), .o_y_axis_enable(ye),
    .o_z_axis_enable(ze), .o_sign(sg), .o_motor_clock(mc),
    .o_dwell_override(ov), .o_setup_active(sa), .o_scan_enable(se),
    .o_ready(rdy), .o_position_match(pm), .o_prog_cmd(cmd),
    .o_prog_match_pulse(pmp), .o_prog_dwell_pulse(pdp));
  axis_stage_model stage (.i_clk(clk), .i_rst_n(rst_n), .i_x_en(xe),
    .i_y_en(ye), .i_z_en(ze), .i_sign(sg), .i_mclk(mc), .o_x(px), .o_y(py),
    .o_z(pz), .o_step(stp));
  // clock source
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // start-stop stand-in: override starts the clock, a digit step stops it
  always @(posedge clk) begin
    cen <= rst_n & (ov | (cen & !stp));
    if (cmd != 3'h0) cseen <= cseen | cmd;
    if (pdp) dseen <= 1'b1;
    if (mc) mseen <= 1'b1;
    if (pmp) pseen <= 1'b1;
    if (ov) ovn <= ovn + 1;
  end
  task chk(input string s, input logic [63:0] g, input logic [63:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // one Avalon access, held until waitrequest is sampled low
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task wait_on(input int b, input logic v);
    wn = 0;
    while (ev[b] !== v && wn < 9000) begin
      @(posedge clk);
      wn++;
    end
    // a wait that runs out counts as a mismatch
    if (ev[b] !== v) n_fail++;
  endtask : wait_on
  task do_reset;
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset
  task press(input logic m);
    if (m) mb <= 1'b1; else ab <= 1'b1;
    repeat (5) @(posedge clk);
    mb <= 1'b0;
    ab <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : press
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
  // main sequence
  initial begin
    {rst_n, rd, wr, ab, mb, dwp} = 6'h00;
    {addr, wd, jog, pxe, pye, pdir} = '0;
    do_reset();
    ab <= 1'b1;
    repeat (10) @(posedge clk);
    chk("ready", rdy, 1'b0);
    ab <= 1'b0;
    wait_on(0, 1'b1);
    chk("hold", wn + 10 >= HC, 1'b1);
    bus(1'b0, scan_mode_pkg::REG_STATUS, 32'h0);
    chk("state", q[4:0], scan_mode_pkg::S_READY);
    chk("lock", q[7], 1'b0);
    for (int i = 1; i < 4; i++) bus(1'b1, 5'(4 * i), i == 1 ? 3 : 2);
    for (int i = 1; i < 4; i++) begin
      bus(1'b0, 5'(4 * i), 32'h0);
      chk("origin", q, i == 1 ? 3 : 2);
    end
    bus(1'b0, 5'h14, 32'h0);
    chk("unmapped", q, 32'h0);
    press(1'b0);
    jog <= 7'h01;
    wait_on(1, 1'b1);
    chk("x sign", {sg, sa}, 2'h3);
    bus(1'b0, scan_mode_pkg::REG_STATUS, 32'h0);
    chk("seq x", q[6:5], scan_mode_pkg::SEQ_INIT);
    chk("jog search", q[14:8], 7'h00);
    jog <= 7'h00;
    wait_on(2, 1'b1);
    chk("y sign", sg, 1'b0);
    bus(1'b0, scan_mode_pkg::REG_STATUS, 32'h0);
    chk("seq y", q[6:5], scan_mode_pkg::SEQ_Y);
    wait_on(3, 1'b1);
    bus(1'b0, scan_mode_pkg::REG_STATUS, 32'h0);
    chk("seq z", q[6:5], scan_mode_pkg::SEQ_Z);
    wait_on(4, 1'b1);
    chk("origins", {px, py, pz}, {11'h003, 11'h002, 11'h002});
    chk("setup clock", mseen, 1'b1);
    press(1'b1);
    bus(1'b0, scan_mode_pkg::REG_STATUS, 32'h0);
    chk("scan", {q[18:17], q[6:0]},
      {2'b00, scan_mode_pkg::SEQ_DONE, scan_mode_pkg::S_SCAN});
    pxe <= 2'h1;
    pdir <= 3'h1;
    repeat (4) @(posedge clk);
    chk("prog x", {xe, ye, ze, sg, pm}, 5'h13);
    pxe <= 2'h0;
    pye <= 2'h2;
    repeat (4) @(posedge clk);
    chk("prog y", {xe, ye, ze, sg, pm}, 5'h09);
    pye <= 2'h0;
    bus(1'b1, scan_mode_pkg::REG_CTRL, 32'hf);
    dwp <= 1'b1;
    @(posedge clk);
    dwp <= 1'b0;
    repeat (4) @(posedge clk);
    chk("prog in", {cseen, dseen, pseen}, 5'h1f);
    o = ovn;
    jog <= 7'h14;
    repeat (4) @(posedge clk);
    jog <= 7'h00;
    wait_on(2, 1'b1);
    chk("fine y", {ze, sg}, 2'h1);
    wait_on(2, 1'b0);
    chk("fine pulses", ovn - o, 1);
    chk("fine step", py, 11'h003);
    bus(1'b0, scan_mode_pkg::REG_STATUS, 32'h0);
    chk("jog clear", q[14:8], 7'h00);
    do_reset();
    wait_on(0, 1'b1);
    press(1'b1);
    bus(1'b0, scan_mode_pkg::REG_STATUS, 32'h0);
    chk("manual", {q[18], q[4:0]}, {1'b1, scan_mode_pkg::S_MANUAL});
    jog <= 7'h04;
    wait_on(2, 1'b1);
    // release well between two steps, clear of the synchroniser delay
    repeat (1300) @(posedge clk);
    chk("override", ov, 1'b1);
    y0 = py;
    jog <= 7'h00;
    wait_on(2, 1'b0);
    chk("stop digit", py, y0 + 11'h001);
    report_and_stop();
  end
endmodule : scan_mode_control_tb
